// ### msq_regs.svh
/*
  Constants for the statistics-queue host controller: tags, sizes, queue index.
  Assumes it is included by the package and by every design file that needs it.
*/
`ifndef MSQ_REGS_SVH
`define MSQ_REGS_SVH

// ----------------------------------------------------------------
// Entry layout
// ----------------------------------------------------------------
`define MSQ_NUM_TAGS 10
`define MSQ_ENTRY_BYTES 4'ha
`define MSQ_LAST_BYTE 4'h9
`define MSQ_TAG_BYTES 4'h2
`define MSQ_LEN_ALIGN 8'h06
`define MSQ_STATS_QUEUE 16'h0002

// ----------------------------------------------------------------
// Statistic tags
// ----------------------------------------------------------------
`define MSQ_TAG_SWAP_IN 4'h0
`define MSQ_TAG_SWAP_OUT 4'h1
`define MSQ_TAG_MAJOR_FAULTS 4'h2
`define MSQ_TAG_MINOR_FAULTS 4'h3
`define MSQ_TAG_FREE_MEMORY 4'h4
`define MSQ_TAG_TOTAL_MEMORY 4'h5
`define MSQ_TAG_AVAILABLE_MEMORY 4'h6
`define MSQ_TAG_CACHE_MEMORY 4'h7
`define MSQ_TAG_HUGEPAGE_ALLOC_OK 4'h8
`define MSQ_TAG_HUGEPAGE_ALLOC_FAIL 4'h9

`endif

// ### msq_pkg.sv
/*
  Types for the statistics-queue host controller.
  Assumes msq_regs.svh is on the include path.
*/
`include "msq_regs.svh"
package msq_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [`MSQ_NUM_TAGS-1:0][63:0] msq_vals_t;

  typedef struct packed {
    logic post;
    logic notify;
    logic driver_ok;
    logic [15:0] queue;
    logic [15:0] length;
  } msq_link_t;

  typedef enum logic [3:0] {
    S_IDLE,
    S_INIT_POST,
    S_INIT_OK,
    S_INIT_NOTIFY,
    S_WAIT_USED,
    S_SEND,
    S_PAD,
    S_POST,
    S_NOTIFY
  } msq_state_t;

endpackage : msq_pkg

// ### msq_byte_sel.sv
/*
  Picks one byte of a 10-byte statistics entry in either byte order.
  Assumes a purely combinational use; the caller registers the result.
*/
`include "msq_regs.svh"
module msq_byte_sel (
  input wire logic [3:0] tag_i,
  input wire logic [63:0] val_i,
  input wire logic [3:0] idx_i,
  input wire logic big_i,
  output logic [7:0] byte_o
);

  // ----------------------------------------------------------------
  // Byte extraction
  // ----------------------------------------------------------------
  function automatic logic [7:0] entry_byte(input logic [15:0] tag, input logic [63:0] val,
                                            input logic [3:0] idx, input logic big);
    logic [3:0] k;
    k = idx;
    if (big) begin
      if (idx < `MSQ_TAG_BYTES) begin
        k = 4'h1 - idx;
      end else begin
        k = 4'hb - idx;
      end
    end
    if (k < `MSQ_TAG_BYTES) begin
      entry_byte = tag[8*k[0] +: 8];
    end else begin
      entry_byte = val[8*(k-4'h2) +: 8];
    end
  endfunction : entry_byte

  always_comb begin
    byte_o = entry_byte({12'h000, tag_i}, val_i, idx_i, big_i);
  end

endmodule : msq_byte_sel

// ### msq_tag_pick.sv
/*
  Finds the lowest supported tag at or above a start index, and counts tags.
  Assumes the mask is stable while a buffer is being built.
*/
`include "msq_regs.svh"
module msq_tag_pick (
  input wire logic [`MSQ_NUM_TAGS-1:0] mask_i,
  input wire logic [3:0] start_i,
  output logic found_o,
  output logic [3:0] idx_o,
  output logic [3:0] count_o
);

  logic [`MSQ_NUM_TAGS-1:0] hit;

  // ----------------------------------------------------------------
  // Candidate tags
  // ----------------------------------------------------------------
  for (genvar g = 0; g < `MSQ_NUM_TAGS; g++) begin : g_hit
    assign hit[g] = mask_i[g] && (4'(g) >= start_i);
  end

  always_comb begin
    found_o = 1'b0;
    idx_o = 4'h0;
    count_o = 4'h0;
    for (int i = `MSQ_NUM_TAGS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        found_o = 1'b1;
        idx_o = 4'(i);
      end
      if (mask_i[i]) begin
        count_o = count_o + 4'h1;
      end
    end
  end

endmodule : msq_tag_pick

// ### msq_host.sv
/*
  Host end of the memory statistics queue: posts the initial empty buffer,
  then answers each used buffer with a fresh buffer of tag/value entries.
  Assumes the device end keeps its own obligations and that tx bytes are
  written into the posted buffer in order before the post pulse.
*/
`include "msq_regs.svh"
module msq_host (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic init_start_i,
  input wire logic stats_queue_feature_i,
  input wire logic legacy_mode_i,
  input wire logic guest_big_endian_i,
  input wire logic [`MSQ_NUM_TAGS-1:0] supported_i,
  input wire msq_pkg::msq_vals_t stats_i,
  input wire logic used_i,
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output msq_pkg::msq_link_t link_o,
  output logic outstanding_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  msq_pkg::msq_state_t state, next_state;
  logic [`MSQ_NUM_TAGS-1:0] mask, next_mask;
  logic feat, next_feat;
  logic big, next_big;
  logic outst, next_outst;
  logic drv_ok, next_drv_ok;
  msq_pkg::msq_vals_t vals, next_vals;
  logic [3:0] cur, next_cur;
  logic [3:0] bidx, next_bidx;
  logic [6:0] cnt, next_cnt;
  logic [6:0] len, next_len;
  logic [7:0] tx_data, next_tx_data;
  logic [3:0] pick_start;
  logic pick_found;
  logic [3:0] pick_idx;
  logic [3:0] pick_count;
  logic [7:0] sel_byte;

  function automatic logic [6:0] padded_len(input logic [3:0] n);
    logic [7:0] raw;
    logic [7:0] rem;
    raw = {4'h0, n} * {4'h0, `MSQ_ENTRY_BYTES};
    rem = raw % `MSQ_LEN_ALIGN;
    if (rem == 8'h00) begin
      padded_len = raw[6:0];
    end else begin
      padded_len = 7'(raw + `MSQ_LEN_ALIGN - rem);
    end
  endfunction : padded_len

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  assign pick_start = (state == msq_pkg::S_WAIT_USED) ? 4'h0 : 4'(cur + 4'h1);

  msq_tag_pick msq_tag_pick_i (
    .mask_i(mask),
    .start_i(pick_start),
    .found_o(pick_found),
    .idx_o(pick_idx),
    .count_o(pick_count)
  );

  msq_byte_sel msq_byte_sel_i (
    .tag_i(next_cur),
    .val_i(next_vals[next_cur]),
    .idx_i(next_bidx),
    .big_i(next_big),
    .byte_o(sel_byte)
  );

  // Padding bytes are zero so a partial trailing entry carries nothing
  assign next_tx_data = (next_state == msq_pkg::S_SEND) ? sel_byte : 8'h00;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_mask = mask;
    next_feat = feat;
    next_big = big;
    next_outst = outst;
    next_drv_ok = drv_ok;
    next_vals = vals;
    next_cur = cur;
    next_bidx = bidx;
    next_cnt = cnt;
    next_len = len;
    case (state)
      msq_pkg::S_IDLE: begin
        if (init_start_i) begin
          next_mask = supported_i;
          next_feat = stats_queue_feature_i;
          next_big = legacy_mode_i && guest_big_endian_i;
          next_len = 7'h00;
          if (stats_queue_feature_i) begin
            next_state = msq_pkg::S_INIT_POST;
          end
        end
      end
      msq_pkg::S_INIT_POST: begin
        next_outst = 1'b1;
        next_state = msq_pkg::S_INIT_OK;
      end
      msq_pkg::S_INIT_OK: begin
        next_drv_ok = 1'b1;
        next_state = msq_pkg::S_INIT_NOTIFY;
      end
      msq_pkg::S_INIT_NOTIFY: begin
        next_state = msq_pkg::S_WAIT_USED;
      end
      msq_pkg::S_WAIT_USED: begin
        if (used_i) begin
          next_outst = 1'b0;
          next_vals = stats_i;
          next_cnt = 7'h00;
          next_bidx = 4'h0;
          if (pick_found) begin
            next_cur = pick_idx;
            next_len = padded_len(pick_count);
            next_state = msq_pkg::S_SEND;
          end else begin
            next_len = 7'h00;
            next_state = msq_pkg::S_POST;
          end
        end
      end
      msq_pkg::S_SEND: begin
        if (tx_ready_i) begin
          next_cnt = 7'(cnt + 7'h01);
          if (bidx == `MSQ_LAST_BYTE) begin
            if (pick_found) begin
              next_cur = pick_idx;
              next_bidx = 4'h0;
            end else if (7'(cnt + 7'h01) == len) begin
              next_state = msq_pkg::S_POST;
            end else begin
              next_state = msq_pkg::S_PAD;
            end
          end else begin
            next_bidx = 4'(bidx + 4'h1);
          end
        end
      end
      msq_pkg::S_PAD: begin
        if (tx_ready_i) begin
          next_cnt = 7'(cnt + 7'h01);
          if (7'(cnt + 7'h01) == len) begin
            next_state = msq_pkg::S_POST;
          end
        end
      end
      msq_pkg::S_POST: begin
        next_outst = 1'b1;
        next_state = msq_pkg::S_NOTIFY;
      end
      msq_pkg::S_NOTIFY: begin
        next_state = msq_pkg::S_WAIT_USED;
      end
      default: begin
        next_state = msq_pkg::S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= msq_pkg::S_IDLE;
      mask <= '0;
      feat <= 1'b0;
      big <= 1'b0;
      outst <= 1'b0;
      drv_ok <= 1'b0;
      vals <= '0;
      cur <= 4'h0;
      bidx <= 4'h0;
      cnt <= 7'h00;
      len <= 7'h00;
      tx_data <= 8'h00;
    end else begin
      state <= next_state;
      mask <= next_mask;
      feat <= next_feat;
      big <= next_big;
      outst <= next_outst;
      drv_ok <= next_drv_ok;
      vals <= next_vals;
      cur <= next_cur;
      bidx <= next_bidx;
      cnt <= next_cnt;
      len <= next_len;
      tx_data <= next_tx_data;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tx_valid_o = (state == msq_pkg::S_SEND) || (state == msq_pkg::S_PAD);
  assign tx_data_o = tx_data;
  assign outstanding_o = outst;
  assign link_o.post = (state == msq_pkg::S_INIT_POST) || (state == msq_pkg::S_POST);
  assign link_o.notify = (state == msq_pkg::S_INIT_NOTIFY) || (state == msq_pkg::S_NOTIFY);
  assign link_o.driver_ok = drv_ok;
  assign link_o.queue = `MSQ_STATS_QUEUE;
  assign link_o.length = {9'h000, len};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  post_single_a : assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    link_o.post |-> !outst ##1 outst)
    else $error("buffer posted while one is outstanding");

  init_order_a : assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (link_o.post && !drv_ok) |-> ##1 (!link_o.notify && !drv_ok) ##1 (drv_ok && link_o.notify))
    else $error("init order post, ready, notify broken");

  feature_gate_a : assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !feat |-> !link_o.post && !link_o.notify && !tx_valid_o)
    else $error("channel active without feature");

  len_align_a : assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    link_o.post |-> (link_o.length % 16'h0006) == 16'h0000)
    else $error("buffer length not a multiple of six");

  len_entries_a : assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (link_o.post && drv_ok) |-> (cnt == len) && (len >= 7'({4'h0, pick_count} * 8'h0a))
      && (len < 7'({4'h0, pick_count} * 8'h0a + 8'h06)))
    else $error("buffer does not hold one entry per statistic");

  used_answer_a : assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (state == msq_pkg::S_WAIT_USED && used_i) |=> !outst && (tx_valid_o || link_o.post))
    else $error("used buffer not answered");

  post_notify_a : assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (link_o.post && drv_ok) |=> link_o.notify ##1 (state == msq_pkg::S_WAIT_USED))
    else $error("post not followed by notify");

  subset_stable_a : assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    drv_ok |=> $stable(mask))
    else $error("statistics subset changed");

  tag_byte_a : assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (state == msq_pkg::S_SEND && bidx == 4'h0) |->
      (tx_data_o == (big ? 8'h00 : {4'h0, cur})) && mask[cur])
    else $error("tag byte wrong for byte order");

endmodule : msq_host

// ### msq_dev_model.sv
/*
  Behavioural model of the device end of the statistics queue.
  Assumes the host writes the buffer bytes in order before each post pulse.
*/
`include "msq_regs.svh"
module msq_dev_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic slow_i,
  input wire logic legacy_i,
  input wire logic big_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire msq_pkg::msq_link_t link_i,
  output logic tx_ready_o,
  output logic used_o,
  output msq_pkg::msq_vals_t vals_o,
  output logic [9:0] seen_o,
  output logic [15:0] len_o,
  output int posts_o,
  output int nbytes_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Buffer capture and parsing
  // ----------------------------------------------------------------
  logic [7:0] mem [0:255];
  int nb;
  logic [15:0] tag;
  logic [63:0] val;
  logic stall;
  logic swap;
  assign tx_ready_o = ~stall;
  assign swap = legacy_i & big_i;
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nb = 0;
      posts_o = 0;
      nbytes_o = 0;
      seen_o = '0;
      vals_o = '0;
      len_o = '0;
      used_o <= 1'b0;
      stall <= 1'b0;
    end else begin
      used_o <= req_i;
      // Stalling every other cycle exercises the host's hold
      stall <= slow_i & ~stall;
      if (tx_valid_i && tx_ready_o) begin
        mem[nb[7:0]] = tx_data_i;
        nb = nb + 1;
      end
      if (link_i.post && link_i.queue == `MSQ_STATS_QUEUE) begin
        len_o = link_i.length;
        nbytes_o = nb;
        for (int e = 0; e + 10 <= nb; e = e + 10) begin
          tag = swap ? {mem[e], mem[e+1]} : {mem[e+1], mem[e]};
          for (int b = 0; b < 8; b++) begin
            val[8*b +: 8] = swap ? mem[e+9-b] : mem[e+2+b];
          end
          if (tag < 16'h000a && !(legacy_i && posts_o == 0)) begin
            vals_o[tag[3:0]] = val;
            seen_o[tag[3:0]] = 1'b1;
          end
        end
        posts_o = posts_o + 1;
        nb = 0;
      end
    end
  end
endmodule : msq_dev_model

// ### tb_memory_stats_queue.sv
/*
  Self-checking bench for the statistics-queue host, against a device model.
  Assumes msq_regs.svh on the include path and the package compiled first.
*/
`include "msq_regs.svh"
module tb_memory_stats_queue;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic init = 1'b0;
  logic feat = 1'b0;
  logic leg = 1'b0;
  logic big = 1'b0;
  logic [9:0] mask = 10'h000;
  msq_pkg::msq_vals_t stats = '0;
  logic req = 1'b0;
  logic slow = 1'b0;
  logic used, rdy, txv, outst;
  logic [7:0] txd;
  msq_pkg::msq_link_t link;
  msq_pkg::msq_vals_t vals;
  logic [9:0] seen;
  logic [15:0] len;
  int posts, nbytes;
  int n_fail = 0;
  int n_checks = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  msq_host msq_host_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .init_start_i(init),
    .stats_queue_feature_i(feat), .legacy_mode_i(leg), .guest_big_endian_i(big),
    .supported_i(mask), .stats_i(stats), .used_i(used), .tx_ready_i(rdy),
    .tx_valid_o(txv), .tx_data_o(txd), .link_o(link), .outstanding_o(outst));
  msq_dev_model msq_dev_model_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req),
    .slow_i(slow), .legacy_i(leg), .big_i(big), .tx_valid_i(txv), .tx_data_i(txd),
    .link_i(link), .tx_ready_o(rdy), .used_o(used), .vals_o(vals), .seen_o(seen),
    .len_o(len), .posts_o(posts), .nbytes_o(nbytes));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic do_reset(input logic f, input logic l, input logic b, input logic [9:0] m);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    slow <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    feat <= f;
    leg <= l;
    big <= b;
    mask <= m;
    init <= 1'b1;
    @(posedge clk_sys_i);
    init <= 1'b0;
  endtask : do_reset
  task automatic wait_posts(input int n);
    for (int i = 0; i < 400 && posts < n; i++) begin
      @(negedge clk_sys_i);
    end
  endtask : wait_posts
  task automatic request(input logic [7:0] seed);
    @(posedge clk_sys_i);
    for (int n = 0; n < 10; n++) begin
      stats[n] <= {seed, 48'h0123_4567_89ab, 4'h0, 4'(n)};
    end
    req <= 1'b1;
    @(posedge clk_sys_i);
    req <= 1'b0;
  endtask : request
  // Values and subset as seen by the device after a post
  task automatic check_buf(input int n);
    int k;
    k = $countones(mask) * 10;
    wait_posts(n);
    check(64'(posts), 64'(n), "post count");
    check(64'(len), 64'((k + 5) / 6 * 6), "posted length");
    check(64'(nbytes), 64'(len), "bytes written");
    check(64'(seen), 64'(mask), "subset");
    for (int t = 0; t < 10; t++) begin
      if (mask[t]) begin
        check(vals[t], stats[t], "tag value");
      end
    end
  endtask : check_buf
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_no_feature();
    do_reset(1'b0, 1'b0, 1'b0, 10'h3ff);
    repeat (20) @(negedge clk_sys_i);
    request(8'h11);
    repeat (150) @(negedge clk_sys_i);
    check(64'(posts), 64'h0, "posts without feature");
    check(64'(link.driver_ok), 64'h0, "ready without feature");
  endtask : s_no_feature
  task automatic s_full_set();
    do_reset(1'b1, 1'b0, 1'b0, 10'h3ff);
    wait_posts(1);
    check(64'(len), 64'h0, "empty first buffer");
    check(64'(link.queue), 64'(`MSQ_STATS_QUEUE), "queue index");
    repeat (3) @(negedge clk_sys_i);
    check(64'(link.driver_ok), 64'h1, "driver ready");
    check(64'(outst), 64'h1, "buffer held");
    request(8'ha5);
    repeat (3) @(posedge clk_sys_i);
    // Used while building must be ignored
    request(8'ha5);
    check_buf(2);
    repeat (150) @(negedge clk_sys_i);
    check(64'(posts), 64'h2, "one buffer outstanding");
    check(64'(outst), 64'h1, "reposted after use");
    @(posedge clk_sys_i);
    slow <= 1'b1;
    request(8'h5c);
    check_buf(3);
    check(vals[9], {8'h5c, 48'h0123_4567_89ab, 8'h09}, "top tag");
  endtask : s_full_set
  task automatic s_legacy(input logic b, input logic [9:0] m);
    do_reset(1'b1, 1'b1, b, m);
    wait_posts(1);
    check(64'(seen), 64'h0, "first legacy buffer");
    request(8'h3c);
    // Look half a cycle after the used pulse is taken, before any repost
    repeat (2) @(negedge clk_sys_i);
    check(64'(outst), 64'h0, "released while building");
    check_buf(2);
  endtask : s_legacy
  initial begin
    s_no_feature();
    s_full_set();
    s_legacy(1'b1, 10'h211);
    s_legacy(1'b0, 10'h0f0);
    s_legacy(1'b1, 10'h000);
    close_out();
  end
  // Whole run is under a thousand cycles; this bound is far above it
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    close_out();
  end
endmodule : tb_memory_stats_queue
